// >>> pkg/mis_regs.svh
// Offsets, field positions, reset values and masks of the mode, interface
// and scratch memory register group.
// Assumes a 16-bit register word and an 8-bit register address.
`ifndef MIS_REGS_SVH
`define MIS_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define MIS_ADDR_OPER_OPT 8'h25
`define MIS_ADDR_LINK_OPT 8'h26
`define MIS_ADDR_MEM_PTR 8'h2B
`define MIS_ADDR_MEM_WORD 8'h2C

// ----------------------------------------------------------------------
// Paged command codes
// ----------------------------------------------------------------------
`define MIS_PAGE_CFG 8'hFF
`define MIS_CMD_OPER_OPT 8'hE9
`define MIS_CMD_MEM_PTR 8'hEF
`define MIS_CMD_MEM_WORD 8'hF0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MIS_OPT_LOW_POWER_BIT 13
`define MIS_OPT_PROT_HI 9
`define MIS_OPT_PROT_LO 8
`define MIS_LNK_TIMEOUT_BIT 12
`define MIS_LNK_PMBUS_BIT 8
`define MIS_LNK_FAST_BIT 2
`define MIS_LNK_GPIO_RB_BIT 0
`define MIS_LNK_WR_MASK 16'h1105
`define MIS_PTR_WR_MASK 16'h00FF

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define MIS_RST_OPER_OPT 16'h0000
`define MIS_RST_LINK_OPT 16'h0000
`define MIS_RST_MEM_PTR 8'h00
`define MIS_RST_MEM_WORD 16'h0000
`define MIS_GPI_PROTECT 4'h5

`endif

// >>> pkg/mis_pkg.sv
// Types shared by the mode, interface and scratch memory register group.
// Assumes the constants header is included by each user.
package mis_pkg;

    // Action taken when protect is asserted
    typedef enum logic [1:0]
    {
        MIS_PROT_HIZ = 2'b00,
        MIS_PROT_NVM = 2'b01,
        MIS_PROT_MLOW = 2'b10,
        MIS_PROT_MHIGH = 2'b11
    } mis_prot_action_t;

    // Code that the outputs are told to take
    typedef enum logic [1:0]
    {
        MIS_CODE_NORMAL = 2'b00,
        MIS_CODE_NVM = 2'b01,
        MIS_CODE_MLOW = 2'b10,
        MIS_CODE_MHIGH = 2'b11
    } mis_code_sel_t;

    // Protect sequencer states
    typedef enum logic [1:0]
    {
        MIS_PS_IDLE = 2'b00,
        MIS_PS_JUMP = 2'b01,
        MIS_PS_SLEW = 2'b10,
        MIS_PS_HIZ = 2'b11
    } mis_prot_state_t;

endpackage

// >>> design/mis_sram.sv
// Scratch memory of 256 words of 16 bits held in flip-flops.
// Assumes one write port and an asynchronous read index from its parent.
`timescale 1ns/100ps
`default_nettype none
`include "mis_regs.svh"
module mis_sram
    import mis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);

    logic [15:0] mem_q [256];
    logic [15:0] mem_d [256];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Next contents: only the addressed word changes
    always_comb
    begin
        mem_d = mem_q;
        if (wr_en_i)
        begin
            mem_d[addr_i] = wdata_i;
        end
    end

    // Cleared at reset so every read is defined
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 256; i++)
            begin
                mem_q[i] <= `MIS_RST_MEM_WORD;
            end
        end
        else
        begin
            mem_q <= mem_d;
        end
    end

    assign rdata_o = mem_q[addr_i];

endmodule // mis_sram
`default_nettype wire

// >>> design/mis_protect.sv
// Protect sequencer: takes the outputs to high-impedance power-down along
// the path chosen by the protect-action field.
// Assumes the channel logic reports the end of a slew on slew_done_i.
`timescale 1ns/100ps
`default_nettype none
module mis_protect
    import mis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic trigger_i,
    input wire logic release_i,
    input wire logic [1:0] action_i,
    input wire logic slew_done_i,
    output logic [1:0] code_sel_o,
    output logic slew_en_o,
    output logic hiz_pdn_o,
    output logic busy_o
);

    mis_prot_state_t state_q, state_d;
    logic [1:0] code_q, code_d;
    logic slew_q, slew_d;
    logic hiz_q, hiz_d;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Action is sampled at the trigger so a later write cannot bend a
    // sequence already under way
    always_comb
    begin
        state_d = state_q;
        code_d = code_q;
        slew_d = slew_q;
        hiz_d = hiz_q;
        unique case (state_q)
            MIS_PS_IDLE:
            begin
                if (trigger_i)
                begin
                    unique case (mis_prot_action_t'(action_i))
                        MIS_PROT_HIZ:
                        begin
                            hiz_d = 1'b1;
                            state_d = MIS_PS_HIZ;
                        end
                        MIS_PROT_NVM:
                        begin
                            code_d = MIS_CODE_NVM;
                            state_d = MIS_PS_JUMP;
                        end
                        MIS_PROT_MLOW:
                        begin
                            code_d = MIS_CODE_MLOW;
                            slew_d = 1'b1;
                            state_d = MIS_PS_SLEW;
                        end
                        MIS_PROT_MHIGH:
                        begin
                            code_d = MIS_CODE_MHIGH;
                            slew_d = 1'b1;
                            state_d = MIS_PS_SLEW;
                        end
                    endcase
                end
            end
            MIS_PS_JUMP:
            begin
                hiz_d = 1'b1;
                state_d = MIS_PS_HIZ;
            end
            MIS_PS_SLEW:
            begin
                if (slew_done_i)
                begin
                    slew_d = 1'b0;
                    hiz_d = 1'b1;
                    state_d = MIS_PS_HIZ;
                end
            end
            MIS_PS_HIZ:
            begin
                if (release_i)
                begin
                    hiz_d = 1'b0;
                    code_d = MIS_CODE_NORMAL;
                    state_d = MIS_PS_IDLE;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= MIS_PS_IDLE;
            code_q <= MIS_CODE_NORMAL;
            slew_q <= 1'b0;
            hiz_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            code_q <= code_d;
            slew_q <= slew_d;
            hiz_q <= hiz_d;
        end
    end

    assign code_sel_o = code_q;
    assign slew_en_o = slew_q;
    assign hiz_pdn_o = hiz_q;
    assign busy_o = (state_q != MIS_PS_IDLE);

endmodule // mis_protect
`default_nettype wire

// >>> design/mis_top.sv
// Mode, interface option and scratch memory register group of a
// quad-channel converter, with the protect sequencer and memory inside.
// Assumes a serial front end that hands over decoded register accesses,
// one per cycle at most, and paged command accesses when that mode is on.
`timescale 1ns/100ps
`default_nettype none
`include "mis_regs.svh"
module mis_top
    import mis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Decoded register access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    // Paged command access
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [7:0] cmd_page_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic hit_o,
    // GPIO pin and its input setup
    input wire logic gpio_i,
    input wire logic gpio_in_en_i,
    input wire logic [3:0] gpio_input_function_select_i,
    output logic gpio_o,
    output logic gpio_oe_o,
    // Serial readback from the front end
    input wire logic readback_data_i,
    input wire logic readback_active_i,
    // Protect sequencing towards the channels
    input wire logic slew_done_i,
    input wire logic protect_release_i,
    output logic [1:0] code_sel_o,
    output logic slew_en_o,
    output logic hiz_pdn_o,
    output logic protect_busy_o,
    // Option levels towards the rest of the device
    output logic low_power_option_bit_o,
    output logic bus_timeout_en_o,
    output logic pmbus_en_o,
    output logic fast_readback_enable_o,
    output logic readback_on_gpio_enable_o
);

    logic [15:0] opt_q, opt_d;
    logic [15:0] lnk_q, lnk_d;
    logic [7:0] ptr_q, ptr_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic gpio_q, gpio_d;
    logic [15:0] mem_rdata;
    logic wr_any, rd_any;
    logic sel_opt, sel_lnk, sel_ptr, sel_word;
    logic mem_wr;
    logic protect_trig;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Map a register address to a one-hot select
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        reg_sel = {a == `MIS_ADDR_MEM_WORD, a == `MIS_ADDR_MEM_PTR,
                   a == `MIS_ADDR_LINK_OPT, a == `MIS_ADDR_OPER_OPT};
    endfunction

    // Map a paged command to the same select; the link register has no code
    function automatic logic [3:0] cmd_sel(input logic [7:0] p, input logic [7:0] c);
        cmd_sel = (p != `MIS_PAGE_CFG) ? 4'h0 :
                  {c == `MIS_CMD_MEM_WORD, c == `MIS_CMD_MEM_PTR,
                   1'b0, c == `MIS_CMD_OPER_OPT};
    endfunction

    logic [3:0] sel_vec;
    logic cmd_ok;

    // Paged commands count only while that protocol is on
    // Gate paged access
    assign cmd_ok = lnk_q[`MIS_LNK_PMBUS_BIT] & (cmd_wr_i | cmd_rd_i);
    assign wr_any = reg_wr_i | (cmd_ok & cmd_wr_i);
    assign rd_any = reg_rd_i | (cmd_ok & cmd_rd_i);

    // Register address wins if the front end ever offers both at once
    // Address and command map
    always_comb
    begin
        if (reg_wr_i || reg_rd_i)
        begin
            sel_vec = reg_sel(reg_addr_i);
        end
        else if (cmd_ok)
        begin
            sel_vec = cmd_sel(cmd_page_i, cmd_code_i);
        end
        else
        begin
            sel_vec = 4'h0;
        end
    end

    assign sel_opt = sel_vec[0];
    assign sel_lnk = sel_vec[1];
    assign sel_ptr = sel_vec[2];
    assign sel_word = sel_vec[3];
    assign hit_o = (wr_any | rd_any) & (|sel_vec);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Operating options keep all bits, the others keep their live bits only
    always_comb
    begin
        opt_d = opt_q;
        lnk_d = lnk_q;
        ptr_d = ptr_q;
        if (wr_any && sel_opt)
        begin
            opt_d = wdata_i;
        end
        if (wr_any && sel_lnk)
        begin
            lnk_d = wdata_i & `MIS_LNK_WR_MASK;
        end
        if (wr_any && sel_ptr)
        begin
            ptr_d = wdata_i[7:0];
        end
        else if (mem_wr)
        begin
            ptr_d = ptr_q + 8'h01;
        end
    end

    assign mem_wr = wr_any & sel_word;

    // Option registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            opt_q <= `MIS_RST_OPER_OPT;
            lnk_q <= `MIS_RST_LINK_OPT;
            ptr_q <= `MIS_RST_MEM_PTR;
        end
        else
        begin
            opt_q <= opt_d;
            lnk_q <= lnk_d;
            ptr_q <= ptr_d;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Read data is held until the next read; unmapped reads return zero
    always_comb
    begin
        rdata_d = rdata_q;
        rvalid_d = rd_any;
        if (rd_any)
        begin
            rdata_d = 16'h0000;
            if (sel_opt)
            begin
                rdata_d = opt_q;
            end
            if (sel_lnk)
            begin
                rdata_d = lnk_q;
            end
            if (sel_ptr)
            begin
                rdata_d = {8'h00, ptr_q};
            end
            if (sel_word)
            begin
                rdata_d = mem_rdata;
            end
        end
    end

    // Read data registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;

    // ------------------------------------------------------------------
    // Scratch memory
    // ------------------------------------------------------------------
    mis_sram u_sram
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(mem_wr),
        .addr_i(ptr_q),
        .wdata_i(wdata_i),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------------
    // Protect input
    // ------------------------------------------------------------------
    // Next pin history is the pin itself; pin is already synchronous
    always_comb
    begin
        gpio_d = gpio_i;
    end

    // Pin history; starts at the high idle level so an idle pin gives no edge after reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gpio_q <= 1'b1;
        end
        else
        begin
            gpio_q <= gpio_d;
        end
    end

    assign protect_trig = gpio_in_en_i & gpio_q & ~gpio_i &
                          (gpio_input_function_select_i == `MIS_GPI_PROTECT);

    mis_protect u_protect
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .trigger_i(protect_trig),
        .release_i(protect_release_i),
        .action_i(opt_q[`MIS_OPT_PROT_HI:`MIS_OPT_PROT_LO]),
        .slew_done_i(slew_done_i),
        .code_sel_o(code_sel_o),
        .slew_en_o(slew_en_o),
        .hiz_pdn_o(hiz_pdn_o),
        .busy_o(protect_busy_o)
    );

    // ------------------------------------------------------------------
    // Option outputs
    // ------------------------------------------------------------------
    assign low_power_option_bit_o = opt_q[`MIS_OPT_LOW_POWER_BIT];
    assign bus_timeout_en_o = lnk_q[`MIS_LNK_TIMEOUT_BIT];
    assign pmbus_en_o = lnk_q[`MIS_LNK_PMBUS_BIT];
    assign fast_readback_enable_o = lnk_q[`MIS_LNK_FAST_BIT];
    assign readback_on_gpio_enable_o = lnk_q[`MIS_LNK_GPIO_RB_BIT];

    // Readback drives the pin only while a read is shifting out, so the
    // pin stays free for input use between frames
    // Readback onto GPIO
    assign gpio_oe_o = lnk_q[`MIS_LNK_GPIO_RB_BIT] & readback_active_i;
    assign gpio_o = gpio_oe_o & readback_data_i;

endmodule // mis_top
`default_nettype wire

// >>> bench/mis_top_sva.sv
// Port-level assertions for the mode, interface and scratch memory group.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module mis_top_sva
    import mis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic cmd_rd_i,
    input wire logic [15:0] wdata_i,
    input wire logic rvalid_o,
    input wire logic hit_o,
    input wire logic gpio_i,
    input wire logic gpio_in_en_i,
    input wire logic [3:0] gpio_input_function_select_i,
    input wire logic gpio_oe_o,
    input wire logic readback_active_i,
    input wire logic slew_done_i,
    input wire logic protect_release_i,
    input wire logic [1:0] code_sel_o,
    input wire logic slew_en_o,
    input wire logic hiz_pdn_o,
    input wire logic protect_busy_o,
    input wire logic low_power_option_bit_o,
    input wire logic bus_timeout_en_o,
    input wire logic pmbus_en_o,
    input wire logic readback_on_gpio_enable_o
);
    // All checks share the one clock and its reset
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_read_gets_valid: assert property (reg_rd_i |=> rvalid_o)
        else $error("read without valid");
    chk_paged_read_refused: assert property (cmd_rd_i && !reg_rd_i && !pmbus_en_o |=> !rvalid_o)
        else $error("paged read answered while off");
    chk_pmbus_bit_kept: assert property (reg_wr_i && reg_addr_i == 8'h26
        |=> pmbus_en_o == $past(wdata_i[8]))
        else $error("paged enable wrong");
    chk_timeout_bit_kept: assert property (reg_wr_i && reg_addr_i == 8'h26
        |=> bus_timeout_en_o == $past(wdata_i[12]))
        else $error("timeout enable wrong");
    chk_low_power_kept: assert property (reg_wr_i && reg_addr_i == 8'h25
        |=> low_power_option_bit_o == $past(wdata_i[13]))
        else $error("low power bit wrong");
    chk_hit_mapped: assert property ((reg_wr_i || reg_rd_i)
        |-> hit_o == (reg_addr_i inside {8'h25, 8'h26, 8'h2B, 8'h2C}))
        else $error("hit flag wrong");
    chk_gpio_drive_gate: assert property (gpio_oe_o == (readback_on_gpio_enable_o && readback_active_i))
        else $error("gpio enable wrong");
    chk_protect_edge_taken: assert property (gpio_in_en_i
        && gpio_input_function_select_i == 4'h5
        && $past(gpio_i) && !gpio_i && !protect_busy_o |=> protect_busy_o)
        else $error("falling edge not taken");
    chk_protect_high_idle: assert property (gpio_i && $past(gpio_i) && !protect_busy_o
        |=> !protect_busy_o)
        else $error("high level started protect");
    chk_slew_end_hiz: assert property (slew_en_o && slew_done_i |=> !slew_en_o && hiz_pdn_o)
        else $error("slew end without power-down");
    chk_stored_code_step: assert property (code_sel_o == 2'b01 && !hiz_pdn_o
        |-> !slew_en_o ##1 hiz_pdn_o)
        else $error("stored code step wrong");
    chk_release_to_normal: assert property (hiz_pdn_o && protect_release_i
        |=> !hiz_pdn_o && code_sel_o == 2'b00)
        else $error("release did not restore");
endmodule // mis_top_sva

bind mis_top mis_top_sva chk (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .cmd_rd_i, .wdata_i, .rvalid_o, .hit_o, .gpio_i, .gpio_in_en_i, .gpio_input_function_select_i,
    .gpio_oe_o, .readback_active_i, .slew_done_i, .protect_release_i, .code_sel_o,
    .slew_en_o, .hiz_pdn_o, .protect_busy_o, .low_power_option_bit_o, .bus_timeout_en_o,
    .pmbus_en_o, .readback_on_gpio_enable_o);
`default_nettype wire

// >>> bench/mis_host_model.sv
// Host controller model issuing decoded and paged register accesses.
// Assumes the register group answers a read one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module mis_host_model (
    input wire logic ref_clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic cmd_wr_o,
    output logic cmd_rd_o,
    output logic [7:0] cmd_page_o,
    output logic [7:0] cmd_code_o,
    output logic [15:0] wdata_o
);
    // Bus idles with strobes low
    initial
    begin
        {reg_wr_o, reg_rd_o, cmd_wr_o, cmd_rd_o} = 4'h0;
        {reg_addr_o, cmd_page_o, cmd_code_o, wdata_o} = 40'h00_0000_0000;
    end

    // One access; an idle cycle first so no strobe is set twice in a step
    task automatic acc(input logic wr, input logic cmd, input logic [7:0] pg,
        input logic [7:0] a, input logic [15:0] d, output logic [15:0] q, output logic v);
        @(posedge ref_clk_i);
        #1;
        {reg_wr_o, reg_rd_o, cmd_wr_o, cmd_rd_o} = {wr & ~cmd, ~wr & ~cmd, wr & cmd, ~wr & cmd};
        {reg_addr_o, cmd_page_o, cmd_code_o, wdata_o} = {a, pg, a, d};
        @(posedge ref_clk_i);
        #1;
        // Released qualifiers show junk, not the last value
        {reg_wr_o, reg_rd_o, cmd_wr_o, cmd_rd_o} = 4'h0;
        {reg_addr_o, cmd_page_o, cmd_code_o, wdata_o} = ~{a, pg, a, d};
        q = rdata_i;
        v = rvalid_i;
    endtask
endmodule // mis_host_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the mode, interface and scratch memory group.
// Assumes the host model drives the register strobes.
`timescale 1ns/100ps
`default_nettype none
`include "mis_regs.svh"
module testbench;
    import mis_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i, reg_rd_i, cmd_wr_i, cmd_rd_i, rvalid_o, hit_o, gpio_o, gpio_oe_o;
    logic [7:0] reg_addr_i, cmd_page_i, cmd_code_i;
    logic [15:0] wdata_i, rdata_o, q, w;
    logic gpio_i = 1'b1;
    logic gpio_in_en_i = 1'b0;
    logic [3:0] gpio_input_function_select_i = 4'h5;
    logic readback_data_i = 1'b0;
    logic readback_active_i = 1'b0;
    logic slew_done_i = 1'b0;
    logic protect_release_i = 1'b0;
    logic [1:0] code_sel_o;
    logic slew_en_o, hiz_pdn_o, protect_busy_o, low_power_option_bit_o, bus_timeout_en_o;
    logic pmbus_en_o, fast_readback_enable_o, readback_on_gpio_enable_o, v;
    logic [15:0] mem [4];
    logic [31:0] rnd = 32'h0000_b61c;
    logic [7:0] p;
    int errors = 0;
    int tests_run = 0;

    // Free-running 10 MHz clock
    always #50 ref_clk_i = ~ref_clk_i;

    mis_top dut (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .cmd_wr_i,
        .cmd_rd_i, .cmd_page_i, .cmd_code_i, .wdata_i, .rdata_o, .rvalid_o, .hit_o, .gpio_i,
        .gpio_in_en_i, .gpio_input_function_select_i, .gpio_o, .gpio_oe_o, .readback_data_i,
        .readback_active_i, .slew_done_i, .protect_release_i, .code_sel_o, .slew_en_o,
        .hiz_pdn_o, .protect_busy_o, .low_power_option_bit_o, .bus_timeout_en_o, .pmbus_en_o,
        .fast_readback_enable_o, .readback_on_gpio_enable_o);

    mis_host_model host (.ref_clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
        .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i), .cmd_page_o(cmd_page_i),
        .cmd_code_o(cmd_code_i), .wdata_o(wdata_i));

    // Right-shifting generator keeps the low half busy from the first step
    task automatic rand16(output logic [15:0] r);
        rnd = {1'b0, rnd[31:1]} ^ (rnd[0] ? 32'h8020_0003 : 32'h0000_0000);
        r = rnd[15:0];
    endtask

    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.acc(1'b1, 1'b0, 8'h00, a, d, q, v);
    endtask

    // Read with valid expected in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host.acc(1'b0, 1'b0, 8'h00, a, 16'h0000, q, v);
        check("rdata", q, e);
        check("rvalid", 16'(v), 16'h0001);
    endtask

    task automatic step();
        @(posedge ref_clk_i);
        #1;
    endtask

    // One protect episode for action a, ended by a release pulse
    task automatic protect(input logic [1:0] a);
        gpio_i = 1'b0;
        step();
        check("hiz", 16'(hiz_pdn_o), 16'(a == 2'b00));
        check("code", 16'(code_sel_o), 16'(a));
        check("slew", 16'(slew_en_o), 16'(a[1]));
        if (a == 2'b01)
        begin
            step();
            check("hiz_nvm", 16'(hiz_pdn_o), 16'h0001);
        end
        if (a[1])
        begin
            rand16(w);
            repeat (w[1:0] + 1) step();
            check("hiz_slew", 16'(hiz_pdn_o), 16'h0000);
            slew_done_i = 1'b1;
            step();
            slew_done_i = 1'b0;
            check("hiz_done", 16'({hiz_pdn_o, slew_en_o}), 16'h0002);
        end
        gpio_i = 1'b1;
        step();
        protect_release_i = 1'b1;
        step();
        protect_release_i = 1'b0;
        check("released", 16'({hiz_pdn_o, protect_busy_o, code_sel_o}), 16'h0000);
    endtask

    // Cuts a hung run short
    initial
    begin
        #2_000_000;
        errors++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        rd(`MIS_ADDR_OPER_OPT, 16'h0000);
        rd(`MIS_ADDR_LINK_OPT, 16'h0000);
        rd(`MIS_ADDR_MEM_PTR, 16'h0000);
        rd(`MIS_ADDR_MEM_WORD, 16'h0000);
        rd(8'h30, 16'h0000);
        wr(`MIS_ADDR_LINK_OPT, 16'hFFFF);
        rd(`MIS_ADDR_LINK_OPT, 16'h1105);
        repeat (4)
        begin
            rand16(w);
            wr(`MIS_ADDR_LINK_OPT, w);
            rd(`MIS_ADDR_LINK_OPT, w & 16'h1105);
            check("opts", 16'({bus_timeout_en_o, pmbus_en_o, fast_readback_enable_o}),
                16'({w[12], w[8], w[2]}));
            rand16(w);
            wr(`MIS_ADDR_OPER_OPT, w);
            rd(`MIS_ADDR_OPER_OPT, w);
            check("low_power", 16'(low_power_option_bit_o), 16'(w[13]));
        end
        rand16(w);
        wr(`MIS_ADDR_MEM_PTR, {w[15:8], 8'hFE});
        rd(`MIS_ADDR_MEM_PTR, 16'h00FE);
        for (int i = 0; i < 4; i++)
        begin
            rand16(mem[i]);
            wr(`MIS_ADDR_MEM_WORD, mem[i]);
        end
        rd(`MIS_ADDR_MEM_PTR, 16'h0002);
        for (int i = 0; i < 4; i++)
        begin
            p = 8'hFE + 8'(i);
            wr(`MIS_ADDR_MEM_PTR, {8'h00, p});
            rd(`MIS_ADDR_MEM_WORD, mem[i]);
            rd(`MIS_ADDR_MEM_WORD, mem[i]);
            rd(`MIS_ADDR_MEM_PTR, {8'h00, p});
        end
        wr(`MIS_ADDR_LINK_OPT, 16'h0000);
        host.acc(1'b0, 1'b1, `MIS_PAGE_CFG, `MIS_CMD_MEM_WORD, 16'h0000, q, v);
        check("refused", 16'(v), 16'h0000);
        wr(`MIS_ADDR_LINK_OPT, 16'h0100);
        rand16(w);
        host.acc(1'b1, 1'b1, `MIS_PAGE_CFG, `MIS_CMD_OPER_OPT, w, q, v);
        rd(`MIS_ADDR_OPER_OPT, w);
        host.acc(1'b1, 1'b1, `MIS_PAGE_CFG, `MIS_CMD_MEM_PTR, 16'h0040, q, v);
        host.acc(1'b1, 1'b1, `MIS_PAGE_CFG, `MIS_CMD_MEM_WORD, ~w, q, v);
        host.acc(1'b0, 1'b1, `MIS_PAGE_CFG, `MIS_CMD_MEM_PTR, 16'h0000, q, v);
        check("paged_ptr", q, 16'h0041);
        rd(`MIS_ADDR_MEM_PTR, 16'h0041);
        wr(`MIS_ADDR_MEM_PTR, 16'h0040);
        host.acc(1'b0, 1'b1, `MIS_PAGE_CFG, `MIS_CMD_MEM_WORD, 16'h0000, q, v);
        check("paged_word", q, ~w);
        for (int e = 0; e < 2; e++)
        begin
            wr(`MIS_ADDR_LINK_OPT, 16'(e));
            repeat (6)
            begin
                step();
                rand16(w);
                {readback_active_i, readback_data_i} = w[1:0];
                #1;
                check("gpio", 16'({gpio_oe_o, gpio_o}), 16'({2{e[0] & w[1]}} & {1'b1, w[0]}));
            end
        end
        readback_active_i = 1'b0;
        gpio_in_en_i = 1'b1;
        gpio_input_function_select_i = 4'h2;
        gpio_i = 1'b0;
        step();
        check("other_func", 16'(protect_busy_o), 16'h0000);
        gpio_i = 1'b1;
        gpio_input_function_select_i = `MIS_GPI_PROTECT;
        for (int a = 0; a < 4; a++)
        begin
            wr(`MIS_ADDR_OPER_OPT, {6'h00, 2'(a), 8'h00});
            protect(2'(a));
        end
        complete_run();
    end
endmodule // testbench
`default_nettype wire
